// [dtcc_pkg.sv]
package dtcc_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int CNT_W = 16;
	localparam int NCH = 6;
	localparam int NGEN = 4;
	localparam int NCTR = 2;
	localparam int SYNC_DEPTH = 4;
	localparam int STAGGER_W = 3;
	localparam int CLKSEL_W = 3;
	localparam int ADDR_W = 8;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLKSEL = 8'h04;
	localparam logic [7:0] ADDR_CHCFG = 8'h08;
	localparam logic [7:0] ADDR_EDGE = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CNT0 = 8'h14;
	localparam logic [7:0] ADDR_CNT1 = 8'h18;
	localparam logic [7:0] ADDR_CHAN_BASE = 8'h20;
	localparam logic [7:0] ADDR_CHAN_LAST = 8'h34;
	// ****************************************
	// Field layouts
	// ****************************************
	localparam int CTRL_W = 6;
	localparam int CTRL_POWER = 0;
	localparam int CTRL_RUN0 = 1;
	localparam int CTRL_CLR0 = 3;
	localparam int CTRL_STAGGER = 5;
	localparam int CLKSEL_STRIDE = 4;
	localparam int CF_CAPCMP = 0;
	localparam int CF_OE = 1;
	localparam int CF_LVL = 2;
	localparam int CF_TB = 3;
	localparam int CF_STRIDE = 4;
	localparam int CHCFG_W = 16;
	localparam int EDGE_W = 12;
	localparam int STAT_RUN0 = 6;
	// ****************************************
	// Values
	// ****************************************
	localparam logic [15:0] CHCFG_RST = 16'h4444;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam int EDGE_RISE = 0;
	localparam int EDGE_FALL = 1;
	localparam int HTRANS_ACTIVE = 1;
endpackage : dtcc_pkg

// [dtcc_top.sv]
// Contract
// - Capture edges masked until one count period passes after counting starts.
// - Edge to capture and interrupt takes three to under four count periods.
// - General channel uses first counter on timebase bit 0, second on 1.
// - Compare mode: counter equal to compare value raises channel interrupt.
// - Free-run: wrap from FFFF to 0000 raises counter wrap interrupt.
// - Compare value 0000 fires as counter reaches 0001.
// - Unwritten compare channel fires right after counter starts.
// - Compare FFFF in free-run fires with wrap interrupt on the wrap.
// - Free-run PWM output holds until first overflow, then goes active.
// - PWM match makes output inactive, raises interrupt, counter keeps counting.
// - Each PWM overflow raises wrap interrupt and reactivates the output.
// - Stagger bit keeps several PWM outputs from activating together.
// - PWM compare value 0000 keeps output inactive forever.
// - PWM compare FFFF: inactive one period after each overflow except first.
// - PWM compare rewrite takes effect only at the next overflow.
// - Match-and-clear: counter equal to limit interrupts and clears counter.
// - Limit channel in match-and-clear mode does not capture.
// - Capture stores assigned counter on selected edge and interrupts.
// - Reading a capture register reports a wrap or clear since last capture.
// - Limit 0000: counter stays zero, limit interrupt stays active.
// - Limit FFFF behaves as free-run with wrap interrupt, no limit interrupt.
// - Free-run counters count 0000 to FFFF, wrap, and continue.
// - Stagger delays outputs one to four by 0 to 3 count periods.
// - Plain compare mode uses a new compare value immediately.
// - Output enable clear holds the output at its inactive level.
`timescale 1ns/1ps
`default_nettype none
module dtcc_top #(
	parameter int PRESC_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [dtcc_pkg::NCH-1:0] capture_input_pin,
	output logic [dtcc_pkg::NGEN-1:0] pwm_output_pin,
	output logic [dtcc_pkg::NCH-1:0] channel_event_irq,
	output logic first_wrap_irq,
	output logic second_wrap_irq
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (PRESC_W < (1 << dtcc_pkg::CLKSEL_W)) begin : g_presc_chk
		$error("PRESC_W too small for the count clock select range");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [dtcc_pkg::CTRL_W-1:0] ctrl;
		logic [dtcc_pkg::NCTR-1:0][dtcc_pkg::CLKSEL_W-1:0] clksel;
		logic [dtcc_pkg::CHCFG_W-1:0] chcfg;
		logic [dtcc_pkg::EDGE_W-1:0] edge_sel;
		logic [dtcc_pkg::NCTR-1:0][dtcc_pkg::CNT_W-1:0] cnt;
		logic [dtcc_pkg::NCTR-1:0][PRESC_W-1:0] presc;
		logic [dtcc_pkg::NCTR-1:0] armed;
		logic [dtcc_pkg::NCH-1:0][dtcc_pkg::CNT_W-1:0] chan;
		logic [dtcc_pkg::NGEN-1:0][dtcc_pkg::CNT_W-1:0] act_cmp;
		logic [dtcc_pkg::NCH-1:0][dtcc_pkg::SYNC_DEPTH-1:0] smp;
		logic [dtcc_pkg::NCH-1:0] wrap_seen;
		logic [dtcc_pkg::NCH-1:0] cap_wrap;
		logic [dtcc_pkg::NCH-1:0] wrap_flag;
		logic [dtcc_pkg::NGEN-1:0] started;
		logic [dtcc_pkg::NGEN-1:0] act;
		logic [dtcc_pkg::NGEN-1:0] rearm;
		logic [dtcc_pkg::NGEN-1:0][dtcc_pkg::STAGGER_W-1:0] dly;
		logic [dtcc_pkg::NGEN-1:0] pin;
		logic [dtcc_pkg::NCH-1:0] ch_irq;
		logic [dtcc_pkg::NCTR-1:0] wrap_irq;
		logic wr_pend;
		logic [dtcc_pkg::ADDR_W-1:0] waddr;
		logic [31:0] rdata;
	} dtcc_state_type;

	dtcc_state_type state_r;
	dtcc_state_type state_nxt;

	logic [dtcc_pkg::NCTR-1:0] run;
	logic [dtcc_pkg::NCTR-1:0] tick;
	logic [dtcc_pkg::NCTR-1:0] wrap_ev;
	logic [dtcc_pkg::NCTR-1:0] clr_ev;
	logic [dtcc_pkg::NCTR-1:0] period_end;

	// ****************************************
	// Helpers
	// ****************************************
	// Count tick every 2**sel system clocks
	function automatic logic tick_of(input logic [PRESC_W-1:0] p,
			input logic [dtcc_pkg::CLKSEL_W-1:0] sel);
		logic [PRESC_W-1:0] m;
		m = PRESC_W'((1 << sel) - 1);
		return (p & m) == m;
	endfunction : tick_of

	// Which counter a channel follows
	function automatic int chan_ctr(input int ch, input logic [dtcc_pkg::CHCFG_W-1:0] cf);
		if (ch == 0) begin
			return 0;
		end else if (ch == dtcc_pkg::NCH - 1) begin
			return 1;
		end
		return int'(cf[(ch - 1) * dtcc_pkg::CF_STRIDE + dtcc_pkg::CF_TB]);
	endfunction : chan_ctr

	function automatic logic is_chan(input logic [dtcc_pkg::ADDR_W-1:0] a);
		return a >= dtcc_pkg::ADDR_CHAN_BASE && a <= dtcc_pkg::ADDR_CHAN_LAST && a[1:0] == 2'b00;
	endfunction : is_chan

	function automatic int chan_idx(input logic [dtcc_pkg::ADDR_W-1:0] a);
		logic [dtcc_pkg::ADDR_W-1:0] d;
		d = a - dtcc_pkg::ADDR_CHAN_BASE;
		return int'(d[dtcc_pkg::ADDR_W-1:2]);
	endfunction : chan_idx

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [dtcc_pkg::CNT_W-1:0] lim;
		logic clr_mode;
		logic capm;
		logic hit;
		logic match;
		logic lvl;
		logic a;
		int k;
		int g;
		lim = '0;
		clr_mode = 1'b0;
		capm = 1'b0;
		hit = 1'b0;
		match = 1'b0;
		lvl = 1'b0;
		a = 1'b0;
		k = 0;
		g = 0;
		state_nxt = state_r;
		run = '0;
		tick = '0;
		wrap_ev = '0;
		clr_ev = '0;
		period_end = '0;

		// Bus write lands in the data phase
		if (state_r.wr_pend) begin
			if (state_r.waddr == dtcc_pkg::ADDR_CTRL) begin
				state_nxt.ctrl = hwdata[dtcc_pkg::CTRL_W-1:0];
			end else if (state_r.waddr == dtcc_pkg::ADDR_CLKSEL) begin
				state_nxt.clksel[0] = hwdata[dtcc_pkg::CLKSEL_W-1:0];
				state_nxt.clksel[1] = hwdata[dtcc_pkg::CLKSEL_STRIDE +: dtcc_pkg::CLKSEL_W];
			end else if (state_r.waddr == dtcc_pkg::ADDR_CHCFG) begin
				state_nxt.chcfg = hwdata[dtcc_pkg::CHCFG_W-1:0];
			end else if (state_r.waddr == dtcc_pkg::ADDR_EDGE) begin
				state_nxt.edge_sel = hwdata[dtcc_pkg::EDGE_W-1:0];
			end else if (is_chan(state_r.waddr)) begin
				state_nxt.chan[chan_idx(state_r.waddr)] = hwdata[dtcc_pkg::CNT_W-1:0];
			end
		end

		// ****************************************
		// Counters
		// ****************************************
		for (int c = 0; c < dtcc_pkg::NCTR; c++) begin
			run[c] = state_r.ctrl[dtcc_pkg::CTRL_POWER] & state_r.ctrl[dtcc_pkg::CTRL_RUN0 + c];
			tick[c] = run[c] & tick_of(state_r.presc[c], state_r.clksel[c]);
			lim = state_r.chan[c * (dtcc_pkg::NCH - 1)];
			clr_mode = state_r.ctrl[dtcc_pkg::CTRL_CLR0 + c];
			wrap_ev[c] = tick[c] & (state_r.cnt[c] == dtcc_pkg::CNT_MAX)
				& (~clr_mode | lim == dtcc_pkg::CNT_MAX);
			clr_ev[c] = tick[c] & clr_mode & (lim != dtcc_pkg::CNT_MAX)
				& (state_r.cnt[c] == lim);
			period_end[c] = wrap_ev[c] | clr_ev[c];
			state_nxt.presc[c] = run[c] ? state_r.presc[c] + 1'b1 : '0;
			if (clr_ev[c]) begin
				state_nxt.cnt[c] = dtcc_pkg::CNT_ZERO;
			end else if (tick[c]) begin
				state_nxt.cnt[c] = state_r.cnt[c] + 1'b1;
			end
			if (!run[c]) begin
				state_nxt.armed[c] = 1'b0;
			end else if (tick[c]) begin
				state_nxt.armed[c] = 1'b1;
			end
			state_nxt.wrap_irq[c] = wrap_ev[c];
		end

		// ****************************************
		// Channels: capture and limit
		// ****************************************
		for (int ch = 0; ch < dtcc_pkg::NCH; ch++) begin
			k = chan_ctr(ch, state_r.chcfg);
			g = ch - 1;
			if (ch == 0 || ch == dtcc_pkg::NCH - 1) begin
				capm = ~state_r.ctrl[dtcc_pkg::CTRL_CLR0 + k];
			end else begin
				capm = ~state_r.chcfg[g * dtcc_pkg::CF_STRIDE + dtcc_pkg::CF_CAPCMP];
			end
			state_nxt.ch_irq[ch] = 1'b0;
			hit = 1'b0;
			// Until the first count tick all stages follow the pin, so the level at start is
			// never seen as an edge
			if (!state_r.armed[k]) begin
				state_nxt.smp[ch] = {dtcc_pkg::SYNC_DEPTH{capture_input_pin[ch]}};
			end else if (tick[k]) begin
				state_nxt.smp[ch] = {state_r.smp[ch][dtcc_pkg::SYNC_DEPTH-2:0],
					capture_input_pin[ch]};
				// Two equal samples mask a one-period glitch's leading edge but not its trailing one; edge shows on the fourth tick
				if (state_r.smp[ch][1] == state_r.smp[ch][2]
						&& state_r.smp[ch][2] != state_r.smp[ch][3]) begin
					hit = state_r.smp[ch][2]
						? state_r.edge_sel[2 * ch + dtcc_pkg::EDGE_RISE]
						: state_r.edge_sel[2 * ch + dtcc_pkg::EDGE_FALL];
				end
			end
			if (capm && hit) begin
				state_nxt.chan[ch] = state_r.cnt[k];
				state_nxt.ch_irq[ch] = 1'b1;
				state_nxt.cap_wrap[ch] = state_r.wrap_seen[ch];
				state_nxt.wrap_seen[ch] = period_end[k];
			end else if (period_end[k]) begin
				state_nxt.wrap_seen[ch] = 1'b1;
			end
			if (!capm && (ch == 0 || ch == dtcc_pkg::NCH - 1)) begin
				state_nxt.ch_irq[ch] = clr_ev[k]
					| (run[k] && state_r.chan[ch] == dtcc_pkg::CNT_ZERO);
			end
		end

		// ****************************************
		// General compare and PWM
		// ****************************************
		for (int gc = 0; gc < dtcc_pkg::NGEN; gc++) begin
			k = chan_ctr(gc + 1, state_r.chcfg);
			capm = ~state_r.chcfg[gc * dtcc_pkg::CF_STRIDE + dtcc_pkg::CF_CAPCMP];
			a = state_r.chcfg[gc * dtcc_pkg::CF_STRIDE + dtcc_pkg::CF_OE];
			lvl = state_r.chcfg[gc * dtcc_pkg::CF_STRIDE + dtcc_pkg::CF_LVL];
			// Compare leaves value N as the counter steps away from it: 0 fires at 1, FFFF on wrap
			match = ~capm & tick[k] & (state_r.cnt[k] == state_r.act_cmp[gc]);
			if (match) begin
				state_nxt.ch_irq[gc + 1] = 1'b1;
			end
			if (!a || !run[k]) begin
				state_nxt.act_cmp[gc] = state_nxt.chan[gc + 1];
			end else if (period_end[k]) begin
				state_nxt.act_cmp[gc] = state_nxt.chan[gc + 1];
			end
			if (!run[k] || capm || !a) begin
				state_nxt.started[gc] = 1'b0;
				state_nxt.act[gc] = 1'b0;
				state_nxt.rearm[gc] = 1'b0;
			end else begin
				if (state_r.rearm[gc] && tick[k]) begin
					state_nxt.act[gc] = 1'b1;
					state_nxt.rearm[gc] = 1'b0;
				end
				if (period_end[k]) begin
					state_nxt.started[gc] = 1'b1;
					if (state_r.started[gc] && match) begin
						state_nxt.act[gc] = 1'b0;
						state_nxt.rearm[gc] = state_nxt.act_cmp[gc] != dtcc_pkg::CNT_ZERO;
					end else begin
						state_nxt.act[gc] = state_nxt.act_cmp[gc] != dtcc_pkg::CNT_ZERO;
					end
				end else if (match) begin
					state_nxt.act[gc] = 1'b0;
				end
			end
			if (tick[k]) begin
				state_nxt.dly[gc] = {state_r.dly[gc][dtcc_pkg::STAGGER_W-2:0], state_r.act[gc]};
			end
			// Both edges go through the same tap, so pulse width is kept
			if (state_r.ctrl[dtcc_pkg::CTRL_STAGGER] && gc > 0) begin
				a = a & state_nxt.dly[gc][gc - 1];
			end else begin
				a = a & state_nxt.act[gc];
			end
			state_nxt.pin[gc] = a ? lvl : ~lvl;
		end

		// ****************************************
		// Bus address phase
		// ****************************************
		state_nxt.wr_pend = 1'b0;
		state_nxt.rdata = '0;
		if (hsel && hready && htrans[dtcc_pkg::HTRANS_ACTIVE]) begin
			if (hwrite) begin
				state_nxt.wr_pend = 1'b1;
				state_nxt.waddr = haddr[dtcc_pkg::ADDR_W-1:0];
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_CTRL) begin
				state_nxt.rdata = 32'(state_nxt.ctrl);
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_CLKSEL) begin
				state_nxt.rdata[dtcc_pkg::CLKSEL_W-1:0] = state_nxt.clksel[0];
				state_nxt.rdata[dtcc_pkg::CLKSEL_STRIDE +: dtcc_pkg::CLKSEL_W] = state_nxt.clksel[1];
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_CHCFG) begin
				state_nxt.rdata = 32'(state_nxt.chcfg);
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_EDGE) begin
				state_nxt.rdata = 32'(state_nxt.edge_sel);
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_STATUS) begin
				state_nxt.rdata = 32'(state_r.wrap_flag);
				state_nxt.rdata[dtcc_pkg::STAT_RUN0 +: dtcc_pkg::NCTR] = run;
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_CNT0) begin
				state_nxt.rdata = 32'(state_r.cnt[0]);
			end else if (haddr[dtcc_pkg::ADDR_W-1:0] == dtcc_pkg::ADDR_CNT1) begin
				state_nxt.rdata = 32'(state_r.cnt[1]);
			end else if (is_chan(haddr[dtcc_pkg::ADDR_W-1:0])) begin
				k = chan_idx(haddr[dtcc_pkg::ADDR_W-1:0]);
				state_nxt.rdata = 32'(state_r.chan[k]);
				// Flag refreshes only on this read; read the channel before the status
				state_nxt.wrap_flag[k] = state_nxt.cap_wrap[k];
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= '0;
			state_r.chcfg <= dtcc_pkg::CHCFG_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Zero-wait slave: ready and OKAY are constant flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = state_r.rdata;
	assign pwm_output_pin = state_r.pin;
	assign channel_event_irq = state_r.ch_irq;
	assign first_wrap_irq = state_r.wrap_irq[0];
	assign second_wrap_irq = state_r.wrap_irq[1];
endmodule : dtcc_top
`default_nettype wire

// [dtcc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port-level checks
// ****************************************
module dtcc_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [5:0] channel_event_irq,
	input wire logic first_wrap_irq,
	input wire logic second_wrap_irq
);
	// Cycles since the last wrap, saturating; a full count takes 65536 ticks
	logic [16:0] gap0_r;
	logic [16:0] gap1_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap0_r <= 17'h00000;
			gap1_r <= 17'h00000;
		end else begin
			gap0_r <= first_wrap_irq ? 17'h00000 : (gap0_r[16] ? gap0_r : gap0_r + 17'h00001);
			gap1_r <= second_wrap_irq ? 17'h00000 : (gap1_r[16] ? gap1_r : gap1_r + 17'h00001);
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_ready_high: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	chk_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
		else $error("hrdata not zero outside a read");
	chk_wrap0_pulse: assert property (first_wrap_irq |=> !first_wrap_irq [*8])
		else $error("first wrap irq longer than one cycle");
	chk_wrap1_pulse: assert property ($rose(second_wrap_irq) |=> $fell(second_wrap_irq))
		else $error("second wrap irq longer than one cycle");
	chk_wrap0_gap: assert property (first_wrap_irq |-> gap0_r >= 17'h0ffff)
		else $error("first counter wrapped early");
	chk_wrap1_gap: assert property (second_wrap_irq |-> gap1_r >= 17'h0ffff)
		else $error("second counter wrapped early");
	chk_chan_pulse: assert property ((channel_event_irq[4:1] != 4'h0) |=>
		((channel_event_irq[4:1] & $past(channel_event_irq[4:1])) == 4'h0))
		else $error("channel irq held two cycles");
endmodule : dtcc_checker
bind dtcc_top dtcc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .channel_event_irq(channel_event_irq),
	.first_wrap_irq(first_wrap_irq), .second_wrap_irq(second_wrap_irq));
`default_nettype wire

// [dtcc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Capture sources and output watcher
// ****************************************
module dtcc_pin_model (
	input wire logic hclk,
	input wire logic clr,
	input wire logic [5:0] level_req,
	output logic [5:0] capture_input_pin,
	input wire logic [3:0] pwm_output_pin,
	output logic [3:0] pwm_seen
);
	// Pins are driven levels, so they change only on a clock edge
	always @(posedge hclk) begin
		capture_input_pin <= level_req;
		pwm_seen <= clr ? 4'h0 : (pwm_seen | pwm_output_pin);
	end
endmodule : dtcc_pin_model
`default_nettype wire

// [dual_timebase_capture_compare_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_timebase_capture_compare_tb;
	logic hclk, hresetn, hsel, hwrite, seen_clr, hreadyout, hresp, first_wrap_irq, second_wrap_irq;
	logic [31:0] haddr, hwdata, hrdata, rdq, rd, rd2;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [5:0] capture_input_pin, level_req, channel_event_irq, seen;
	logic [3:0] pwm_output_pin, pwm_seen;
	int failures, samples_checked, t, pc0 = 0, pc0_base;
	wire logic hready;
	assign hready = hreadyout;
	initial hclk = 1'b0;
	always #2.5 hclk = ~hclk;
	always @(posedge hclk) begin
		rdq <= hrdata;
		seen <= seen_clr ? 6'h00 : (seen | channel_event_irq);
		if (channel_event_irq[0] === 1'b1) pc0 <= pc0 + 1;
	end
	dtcc_top #(.PRESC_W(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.capture_input_pin(capture_input_pin), .pwm_output_pin(pwm_output_pin),
		.channel_event_irq(channel_event_irq), .first_wrap_irq(first_wrap_irq),
		.second_wrap_irq(second_wrap_irq));
	dtcc_pin_model u_pins (.hclk(hclk), .clr(seen_clr), .level_req(level_req),
		.capture_input_pin(capture_input_pin), .pwm_output_pin(pwm_output_pin),
		.pwm_seen(pwm_seen));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		#1 rd = rdq;
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	task automatic cyc1;
		@(posedge hclk);
		#1;
	endtask : cyc1
	task automatic wait_seen(input int b, input int lim);
		t = 0;
		while (seen[b] !== 1'b1 && t < lim) begin
			cyc1();
			t++;
		end
	endtask : wait_seen
	task automatic clr_seen;
		@(posedge hclk);
		seen_clr <= 1'b1;
		@(posedge hclk);
		seen_clr <= 1'b0;
		#1;
	endtask : clr_seen
	task automatic do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset
	task automatic end_sim;
		$display("checked=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (90000) @(posedge hclk);
		failures++;
		end_sim();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		level_req = 6'h00;
		seen_clr = 1'b1;
		failures = 0;
		samples_checked = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		seen_clr <= 1'b0;
		rdchk(dtcc_pkg::ADDR_CHCFG, {16'h0000, dtcc_pkg::CHCFG_RST});
		rdchk(dtcc_pkg::ADDR_CTRL, 32'h0);
		bus(8'h40, 1'b1, 32'h1234);
		rdchk(8'h40, 32'h0);
		bus(8'h24, 1'b1, 32'h0005);
		rdchk(8'h24, 32'h0005);
		$display("test registers done");
		// Channel values are only written while the counters stand still
		bus(dtcc_pkg::ADDR_CHCFG, 1'b1, 32'h4cd5);
		bus(8'h28, 1'b1, 32'h0005);
		bus(dtcc_pkg::ADDR_EDGE, 1'b1, 32'h0040);
		bus(dtcc_pkg::ADDR_CLKSEL, 1'b1, 32'h0);
		clr_seen();
		bus(dtcc_pkg::ADDR_CTRL, 1'b1, 32'h05);
		wait_seen(2, 30);
		chk({31'h0, t >= 4 && t <= 12}, 32'h1);
		chk({31'h0, seen[1]}, 32'h0);
		rdchk(dtcc_pkg::ADDR_CNT0, 32'h0);
		bus(dtcc_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk({30'h0, rd[7:6]}, 32'h2);
		$display("test timebase done");
		clr_seen();
		level_req[3] <= 1'b1;
		wait_seen(3, 12);
		chk({31'h0, t >= 3 && t <= 7}, 32'h1);
		bus(8'h2c, 1'b0, 32'h0);
		rd2 = rd;
		bus(dtcc_pkg::ADDR_CNT1, 1'b0, 32'h0);
		chk({31'h0, rd2 != 32'h0 && rd2 < rd}, 32'h1);
		clr_seen();
		level_req[3] <= 1'b0;
		repeat (12) cyc1();
		chk({31'h0, seen[3]}, 32'h0);
		$display("test capture done");
		do_reset();
		bus(dtcc_pkg::ADDR_CLKSEL, 1'b1, 32'h0);
		bus(dtcc_pkg::ADDR_CHAN_BASE, 1'b1, 32'h0008);
		bus(dtcc_pkg::ADDR_CHAN_LAST, 1'b1, 32'h0000);
		clr_seen();
		bus(dtcc_pkg::ADDR_CTRL, 1'b1, 32'h1f);
		wait_seen(0, 20);
		chk({31'h0, t < 20}, 32'h1);
		pc0_base = pc0;
		repeat (90) cyc1();
		chk({31'h0, pc0 - pc0_base >= 9 && pc0 - pc0_base <= 11}, 32'h1);
		bus(dtcc_pkg::ADDR_CNT0, 1'b0, 32'h0);
		chk({31'h0, rd <= 32'h8}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			cyc1();
			chk({31'h0, channel_event_irq[5]}, 32'h1);
		end
		rdchk(dtcc_pkg::ADDR_CNT1, 32'h0);
		$display("test match clear done");
		// All four outputs reach active on the same clear, so only the stagger separates them
		do_reset();
		bus(dtcc_pkg::ADDR_CLKSEL, 1'b1, 32'h0);
		bus(dtcc_pkg::ADDR_CHCFG, 1'b1, 32'h7777);
		bus(dtcc_pkg::ADDR_CHAN_BASE, 1'b1, 32'h000f);
		for (int i = 1; i < 5; i++) begin
			bus(8'(dtcc_pkg::ADDR_CHAN_BASE + 4 * i), 1'b1, 32'h0008);
		end
		bus(dtcc_pkg::ADDR_CTRL, 1'b1, 32'h2b);
		t = 0;
		while (pwm_output_pin[0] !== 1'b1 && t < 40) begin
			cyc1();
			t++;
		end
		for (int i = 0; i < 4; i++) begin
			chk({28'h0, pwm_output_pin}, 32'((2 << i) - 1));
			cyc1();
		end
		$display("test stagger done");
		do_reset();
		bus(dtcc_pkg::ADDR_CLKSEL, 1'b1, 32'h0);
		bus(dtcc_pkg::ADDR_CHCFG, 1'b1, 32'h5775);
		bus(8'h24, 1'b1, 32'hffff);
		bus(8'h28, 1'b1, 32'h0010);
		bus(8'h2c, 1'b1, 32'h0000);
		bus(8'h30, 1'b1, 32'h0000);
		clr_seen();
		bus(dtcc_pkg::ADDR_CTRL, 1'b1, 32'h07);
		wait_seen(4, 10);
		chk({31'h0, t < 10}, 32'h1);
		t = 0;
		while (first_wrap_irq !== 1'b1 && t < 70000) begin
			cyc1();
			t++;
		end
		chk({31'h0, first_wrap_irq}, 32'h1);
		chk({31'h0, second_wrap_irq}, 32'h1);
		chk({31'h0, channel_event_irq[1]}, 32'h1);
		chk({28'h0, pwm_seen}, 32'h0);
		t = 0;
		while (pwm_output_pin[1] !== 1'b1 && t < 8) begin
			cyc1();
			t++;
		end
		chk({31'h0, pwm_output_pin[1]}, 32'h1);
		clr_seen();
		t = 0;
		while (pwm_output_pin[1] === 1'b1 && t < 30) begin
			cyc1();
			t++;
		end
		chk({31'h0, pwm_output_pin[1]}, 32'h0);
		chk({31'h0, channel_event_irq[2]}, 32'h1);
		chk({31'h0, pwm_seen[2]}, 32'h0);
		chk({28'h0, pwm_seen & 4'h9}, 32'h0);
		$display("test free run done");
		end_sim();
	end
endmodule : dual_timebase_capture_compare_tb
`default_nettype wire
